// File: common/dcsp_defs.vh
`ifndef DCSP_DEFS_VH
`define DCSP_DEFS_VH

// ==========================================================
// Register offsets (word index on the register port)
`define DCSP_OFS_PIN_FUNC 6'h04
`define DCSP_OFS_CH1_MODE_A 6'h05
`define DCSP_OFS_CH1_SHIFT_LOW 6'h06
`define DCSP_OFS_CH1_SHIFT_HIGH 6'h07
`define DCSP_OFS_DRIVE_CTRL 6'h0C
`define DCSP_OFS_CH2_MODE_A 6'h1B
`define DCSP_OFS_CH2_MODE_B 6'h1C
`define DCSP_OFS_CH2_SHIFT_LOW 6'h1D
`define DCSP_OFS_CH2_SHIFT_HIGH 6'h1E
`define DCSP_OFS_CH1_MODE_B 6'h28

// ==========================================================
// Reset values
`define DCSP_RST_4BIT 4'h0

// ==========================================================
// Field positions
`define DCSP_MODEA_PIN 3
`define DCSP_PF_IN1 0
`define DCSP_PF_OUT1 1
`define DCSP_PF_IN2 2
`define DCSP_PF_OUT2 3
`define DCSP_DRV_PMOS1 0
`define DCSP_MB_PRESCALE 0
`define DCSP_MB_IDLE 1
`define DCSP_MB_PMOS 2

// ==========================================================
// Clock select code for the external clock
`define DCSP_EXT_CLK 3'h7

// ==========================================================
// Half periods of the generated clock, in clk_sys cycles
`define DCSP_HALF_0 13'h0800
`define DCSP_HALF_1 13'h0200
`define DCSP_HALF_2 13'h0080
`define DCSP_HALF_3 13'h0020
`define DCSP_HALF_4 13'h0008
`define DCSP_HALF_5 13'h0002

`endif

// File: verilog/dcsp_top.v
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "dcsp_defs.vh"

// ==========================================================
// One serial channel
module dcsp_chan (
    input wire clk_sys,
    input wire reset_n,
    input wire mode_wr,
    input wire [3:0] wdata,
    input wire start,
    input wire sr_wr_lo,
    input wire sr_wr_hi,
    input wire prescale_sel,
    input wire idle_level,
    input wire cont_ok,
    input wire sck_s,
    input wire si_s,
    input wire irq_clr,
    output reg [7:0] shift_data,
    output reg sck_gen,
    output reg sck_drive,
    output reg so_bit,
    output reg irq_flag
);
    localparam ST_WAIT = 4'h1;
    localparam ST_CLKW = 4'h2;
    localparam ST_XFER = 4'h4;
    localparam ST_CONT = 4'h8;

    reg [3:0] mode_a;
    reg [3:0] mode_act;
    reg [3:0] state;
    reg [2:0] bit_cnt;
    reg first_low;
    reg [12:0] hcnt;
    reg sck_prev;

    // Half period minus one for the selected ratio
    function [12:0] dcsp_half;
        input b0;
        input [2:0] sel;
        reg [12:0] h;
        begin
            h = `DCSP_HALF_5;
            case (sel)
                3'h0: h = `DCSP_HALF_0;
                3'h1: h = `DCSP_HALF_1;
                3'h2: h = `DCSP_HALF_2;
                3'h3: h = `DCSP_HALF_3;
                3'h4: h = `DCSP_HALF_4;
                default: h = `DCSP_HALF_5;
            endcase
            if (b0) begin
                h = {h[11:0], 1'b0};
            end
            dcsp_half = h - 13'h0001;
        end
    endfunction

    wire ext = (mode_act[2:0] == `DCSP_EXT_CLK);
    wire in_xfer = (state == ST_XFER);
    wire gen_run = ~ext & (state == ST_CLKW | in_xfer | state == ST_CONT);
    wire tick = gen_run & (hcnt == 13'h0000);
    // Clock held off while idle or in the cycle of a mode write
    wire fall_ev = ~mode_wr & (ext ? (sck_prev & ~sck_s) : (tick & sck_gen));
    wire rise_ev = ~mode_wr & (ext ? (~sck_prev & sck_s) : (tick & ~sck_gen));
    wire go_cont = ~ext & cont_ok;
    wire last_rise = in_xfer & rise_ev & ~start & (bit_cnt == 3'h7);
    // Abort in the first low pulse raises no flag
    wire abort = in_xfer & (mode_wr | start) & ~first_low;
    wire set_irq = last_rise | abort;

    // Mode A holding and the one-cycle-late active copy
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            mode_a <= `DCSP_RST_4BIT;
            mode_act <= `DCSP_RST_4BIT;
        end else begin
            if (mode_wr) begin
                mode_a <= wdata;
            end
            mode_act <= mode_a;
        end
    end

    // Prescaler and generated clock; idle high
    always @(posedge clk_sys) begin
        if (!reset_n || mode_wr || !gen_run) begin
            sck_gen <= 1'b1;
            hcnt <= dcsp_half(prescale_sel, mode_act[2:0]);
        end else if (tick) begin
            sck_gen <= ~sck_gen;
            hcnt <= dcsp_half(prescale_sel, mode_act[2:0]);
        end else begin
            hcnt <= hcnt - 13'h0001;
        end
    end

    // Edge detector looks only at the settled copy
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            sck_prev <= 1'b1;
            sck_drive <= 1'b0;
        end else begin
            sck_prev <= sck_s;
            sck_drive <= ~ext & mode_act[`DCSP_MODEA_PIN];
        end
    end

    // Channel state, octal counter and interrupt flag
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= ST_WAIT;
            bit_cnt <= 3'h0;
            first_low <= 1'b0;
            irq_flag <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            irq_flag <= set_irq | (irq_flag & ~irq_clr);
            if (mode_wr) begin
                state <= ST_WAIT;
                bit_cnt <= 3'h0;
                first_low <= 1'b0;
            end else begin
                case (state)
                    ST_WAIT: begin
                        if (start) begin
                            state <= ST_CLKW;
                        end
                    end
                    ST_CLKW: begin
                        if (fall_ev && !start) begin
                            state <= go_cont ? ST_CONT : ST_XFER;
                            first_low <= ~go_cont;
                        end
                    end
                    ST_XFER: begin
                        if (start) begin
                            state <= ST_CLKW;
                            bit_cnt <= 3'h0;
                            first_low <= 1'b0;
                        end else if (rise_ev) begin
                            first_low <= 1'b0;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                // Internal clock stops after the eighth pulse
                                state <= ext ? ST_CLKW : ST_WAIT;
                            end
                        end
                    end
                    ST_CONT: begin
                        state <= ST_CONT;
                    end
                    default: begin
                        state <= ST_WAIT;
                    end
                endcase
            end
        end
    end

    // Shift register; no reset, contents are software data
    always @(posedge clk_sys) begin
        if (sr_wr_lo) begin
            shift_data[3:0] <= wdata;
        end else if (sr_wr_hi) begin
            shift_data[7:4] <= wdata;
        end else if (in_xfer && rise_ev && !start) begin
            shift_data <= {si_s, shift_data[7:1]};
        end
    end

    // Serial output: data bit in transfer, idle level otherwise
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            so_bit <= 1'b1;
        end else if (fall_ev && !start && (in_xfer || (state == ST_CLKW && !go_cont))) begin
            so_bit <= shift_data[0];
        end else if (!in_xfer) begin
            so_bit <= idle_level;
        end
    end
endmodule

// ==========================================================
// Register port, pin synchronisers and pin drivers
module dcsp_top (
    input wire clk_sys,
    input wire reset_n,
    input wire [5:0] reg_addr,
    input wire [3:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [3:0] reg_rdata,
    input wire ch1_start_instr,
    input wire ch1_irq_clr,
    input wire ch2_irq_clr,
    output wire ch1_irq_flag,
    output wire ch2_irq_flag,
    input wire ch1_shift_clock_in,
    output reg ch1_shift_clock_out,
    output reg ch1_shift_clock_oe,
    input wire ch1_serial_in,
    output reg ch1_serial_out,
    output reg ch1_serial_out_oe,
    input wire ch2_shift_clock_in,
    output reg ch2_shift_clock_out,
    output reg ch2_shift_clock_oe,
    input wire ch2_serial_in,
    output reg ch2_serial_out,
    output reg ch2_serial_out_oe
);
    reg [3:0] serial_pin_function;
    reg [3:0] output_drive_control;
    reg [1:0] ch1_mode_b;
    reg [2:0] ch2_mode_b;
    reg [3:0] pin_s1;
    reg [3:0] pin_s2;
    wire [7:0] c1_sr;
    wire [7:0] c2_sr;
    wire c1_sck;
    wire c2_sck;
    wire c1_drv;
    wire c2_drv;
    wire c1_so;
    wire c2_so;

    // Address decode helper
    function hit;
        input [5:0] a;
        input [5:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire wr_m1a = reg_wr & hit(reg_addr, `DCSP_OFS_CH1_MODE_A);
    wire wr_m2a = reg_wr & hit(reg_addr, `DCSP_OFS_CH2_MODE_A);
    // Reading channel-2 mode A is that channel's start instruction
    wire rd_m2a = reg_rd & hit(reg_addr, `DCSP_OFS_CH2_MODE_A);

    // Two-stage synchronisers: ch2 data, ch2 clock, ch1 data, ch1 clock
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_s1 <= 4'hF;
            pin_s2 <= 4'hF;
        end else begin
            pin_s1 <= {ch2_serial_in, ch2_shift_clock_in, ch1_serial_in, ch1_shift_clock_in};
            pin_s2 <= pin_s1;
        end
    end

    // Write-only configuration registers
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            serial_pin_function <= `DCSP_RST_4BIT;
            output_drive_control <= `DCSP_RST_4BIT;
            ch1_mode_b[`DCSP_MB_PRESCALE] <= 1'b0;
            ch2_mode_b[`DCSP_MB_PRESCALE] <= 1'b0;
            ch2_mode_b[`DCSP_MB_PMOS] <= 1'b0;
        end else if (reg_wr) begin
            if (hit(reg_addr, `DCSP_OFS_PIN_FUNC)) begin
                serial_pin_function <= reg_wdata;
            end
            if (hit(reg_addr, `DCSP_OFS_DRIVE_CTRL)) begin
                output_drive_control <= reg_wdata;
            end
            if (hit(reg_addr, `DCSP_OFS_CH1_MODE_B)) begin
                ch1_mode_b[`DCSP_MB_PRESCALE] <= reg_wdata[0];
            end
            if (hit(reg_addr, `DCSP_OFS_CH2_MODE_B)) begin
                ch2_mode_b[`DCSP_MB_PRESCALE] <= reg_wdata[0];
                ch2_mode_b[`DCSP_MB_PMOS] <= reg_wdata[2];
            end
        end
        // Idle-level bits keep their value through reset
        if (reg_wr && hit(reg_addr, `DCSP_OFS_CH1_MODE_B)) begin
            ch1_mode_b[`DCSP_MB_IDLE] <= reg_wdata[1];
        end
        if (reg_wr && hit(reg_addr, `DCSP_OFS_CH2_MODE_B)) begin
            ch2_mode_b[`DCSP_MB_IDLE] <= reg_wdata[1];
        end
    end

    // Read data one cycle after the strobe; write-only words read zero
    always @(posedge clk_sys) begin
        if (!reset_n || !reg_rd) begin
            reg_rdata <= 4'h0;
        end else begin
            case (reg_addr)
                `DCSP_OFS_CH1_SHIFT_LOW: reg_rdata <= c1_sr[3:0];
                `DCSP_OFS_CH1_SHIFT_HIGH: reg_rdata <= c1_sr[7:4];
                `DCSP_OFS_CH2_SHIFT_LOW: reg_rdata <= c2_sr[3:0];
                `DCSP_OFS_CH2_SHIFT_HIGH: reg_rdata <= c2_sr[7:4];
                default: reg_rdata <= 4'h0;
            endcase
        end
    end

    dcsp_chan u_ch1 (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .mode_wr(wr_m1a),
        .wdata(reg_wdata),
        .start(ch1_start_instr),
        .sr_wr_lo(reg_wr & hit(reg_addr, `DCSP_OFS_CH1_SHIFT_LOW)),
        .sr_wr_hi(reg_wr & hit(reg_addr, `DCSP_OFS_CH1_SHIFT_HIGH)),
        .prescale_sel(ch1_mode_b[`DCSP_MB_PRESCALE]),
        .idle_level(ch1_mode_b[`DCSP_MB_IDLE]),
        .cont_ok(~serial_pin_function[`DCSP_PF_IN1] & ~serial_pin_function[`DCSP_PF_OUT1]),
        .sck_s(pin_s2[0]),
        .si_s(pin_s2[1]),
        .irq_clr(ch1_irq_clr),
        .shift_data(c1_sr),
        .sck_gen(c1_sck),
        .sck_drive(c1_drv),
        .so_bit(c1_so),
        .irq_flag(ch1_irq_flag)
    );

    dcsp_chan u_ch2 (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .mode_wr(wr_m2a),
        .wdata(reg_wdata),
        .start(rd_m2a),
        .sr_wr_lo(reg_wr & hit(reg_addr, `DCSP_OFS_CH2_SHIFT_LOW)),
        .sr_wr_hi(reg_wr & hit(reg_addr, `DCSP_OFS_CH2_SHIFT_HIGH)),
        .prescale_sel(ch2_mode_b[`DCSP_MB_PRESCALE]),
        .idle_level(ch2_mode_b[`DCSP_MB_IDLE]),
        .cont_ok(~serial_pin_function[`DCSP_PF_IN2] & ~serial_pin_function[`DCSP_PF_OUT2]),
        .sck_s(pin_s2[2]),
        .si_s(pin_s2[3]),
        .irq_clr(ch2_irq_clr),
        .shift_data(c2_sr),
        .sck_gen(c2_sck),
        .sck_drive(c2_drv),
        .so_bit(c2_so),
        .irq_flag(ch2_irq_flag)
    );

    // Pin drivers; with PMOS off the serial data output is open drain
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ch1_shift_clock_out <= 1'b1;
            ch1_shift_clock_oe <= 1'b0;
            ch1_serial_out <= 1'b1;
            ch1_serial_out_oe <= 1'b0;
            ch2_shift_clock_out <= 1'b1;
            ch2_shift_clock_oe <= 1'b0;
            ch2_serial_out <= 1'b1;
            ch2_serial_out_oe <= 1'b0;
        end else begin
            ch1_shift_clock_out <= c1_sck;
            ch1_shift_clock_oe <= c1_drv;
            ch1_serial_out <= c1_so;
            ch1_serial_out_oe <= serial_pin_function[`DCSP_PF_OUT1]
                & (output_drive_control[`DCSP_DRV_PMOS1] | ~c1_so);
            ch2_shift_clock_out <= c2_sck;
            ch2_shift_clock_oe <= c2_drv;
            ch2_serial_out <= c2_so;
            ch2_serial_out_oe <= serial_pin_function[`DCSP_PF_OUT2]
                & (ch2_mode_b[`DCSP_MB_PMOS] | ~c2_so);
        end
    end
endmodule

// File: tb/dcsp_asserts.sv
`timescale 1ns/100ps
// ==========================================
// Port checks for the serial block
module dcsp_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [5:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_rdata,
    input wire logic ch1_irq_clr,
    input wire logic ch1_start_instr,
    input wire logic ch1_irq_flag,
    input wire logic ch2_irq_flag,
    input wire logic ch1_shift_clock_out,
    input wire logic ch2_shift_clock_out,
    input wire logic ch1_shift_clock_oe,
    input wire logic ch1_serial_out,
    input wire logic ch2_serial_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Write-only places read back as zero
    a_mode_a_wo: assert property (reg_rd && reg_addr == 6'h05 |=> reg_rdata == 4'h0)
        else $error("mode A read not zero");
    a_pin_func_wo: assert property (
        reg_rd && reg_addr inside {6'h04, 6'h0C} |=> !reg_rdata)
        else $error("pin function read not zero");
    // Channel-1 clock line high and its flag clear straight after reset
    a_clk_after_reset: assert property (
        $rose(reset_n) |-> ch1_shift_clock_out && !ch1_irq_flag)
        else $error("clock not idle after reset");
    // Mode A write blocks the clock; a start two cycles on may restart it
    a_mode1_blocks: assert property (
        reg_wr && reg_addr == 6'h05 |-> ##2 ch1_shift_clock_out [*4])
        else $error("ch1 clock runs after mode A write");
    a_mode2_blocks: assert property (
        reg_wr && reg_addr == 6'h1B |-> ##2 ch2_shift_clock_out [*4])
        else $error("ch2 clock runs after mode A write");
    // Pin enable passes the active copy, the drive flag and the pin flop
    a_pin_release: assert property (
        reg_wr && reg_addr == 6'h05 && !reg_wdata[3] |-> ##4 !ch1_shift_clock_oe)
        else $error("clock pin still driven");
    // Idle level reaches the pin through the channel and pin registers
    a_idle1_level: assert property (
        reg_wr && reg_addr == 6'h28 |-> ##3 ch1_serial_out == $past(reg_wdata[1], 3))
        else $error("ch1 idle level wrong");
    a_idle2_level: assert property (
        reg_wr && reg_addr == 6'h1C |-> ##3 ch2_serial_out == $past(reg_wdata[1], 3))
        else $error("ch2 idle level wrong");
    a_irq1_sticky: assert property (ch1_irq_flag && !ch1_irq_clr |=> ch1_irq_flag)
        else $error("ch1 flag dropped");
    // A start in transfer keeps the clock running, so it is left out
    a_stop_after_eight: assert property (
        $rose(ch1_irq_flag) && !$past(ch1_start_instr) |=> ch1_shift_clock_out [*4])
        else $error("ch1 clock runs after end");
    c_ch1_done: cover property ($rose(ch1_irq_flag));
    c_ch2_done: cover property ($rose(ch2_irq_flag));
    c_ch2_start: cover property (reg_rd && reg_addr == 6'h1B);
endmodule

// File: tb/dcsp_peer.sv
`timescale 1ns/100ps
// ==========================================
// Serial peer: samples at rise, changes its bit just after the rise
// so the device sees it settled for all but four clk_sys cycles of a period before sampling
module dcsp_peer (
    input wire logic clk_sys,
    input wire logic sck,
    input wire logic so,
    input wire logic load,
    input wire logic [7:0] tx,
    output logic si,
    output logic [7:0] got,
    output logic [3:0] cnt
);
    logic sck_d;
    logic [7:0] sh;
    initial begin
        si = 1'b1;
        sck_d = 1'b1;
        cnt = 4'h0;
    end
    // Rising edge of the clock pin moves one bit each way
    always @(posedge clk_sys) begin
        sck_d <= sck;
        if (load) begin
            sh <= tx;
            si <= tx[0];
            cnt <= 4'h0;
        end else if (sck && !sck_d) begin
            got <= {so, got[7:1]};
            sh <= {1'b0, sh[7:1]};
            si <= (cnt == 4'h7) ? !si : sh[1];
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// File: tb/dcsp_top_tb.sv
`timescale 1ns/100ps
// ==========================================
// Bench for the dual serial block
module dcsp_top_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic ch1_start_instr = 1'b0;
    logic [1:0] irq_clr = 2'b00;
    logic [1:0] ext_sck = 2'b11;
    logic [1:0] pload = 2'b00;
    logic [7:0] ptx [2];
    logic [7:0] pgot [2];
    logic [3:0] pcnt [2];
    logic [3:0] expq [$];
    logic [5:0] wo [6] = '{6'h04, 6'h05, 6'h0C, 6'h1C, 6'h28, 6'h3F};
    integer n_errors = 0;
    integer comparisons = 0;
    integer cycles = 0;
    wire [3:0] reg_rdata;
    wire [1:0] irq, si, sck_out, sck_oe, so_out, so_oe;
    // Pin levels: released clock follows the bench, released data pulls up
    wire [1:0] sck_w = (sck_oe & sck_out) | (~sck_oe & ext_sck);
    wire [1:0] so_w = ~so_oe | so_out;

    always #2.5 clk_sys = !clk_sys;

    dcsp_top dcsp_top_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ch1_start_instr(ch1_start_instr), .ch1_irq_clr(irq_clr[0]), .ch2_irq_clr(irq_clr[1]),
        .ch1_irq_flag(irq[0]), .ch2_irq_flag(irq[1]),
        .ch1_shift_clock_in(sck_w[0]), .ch1_shift_clock_out(sck_out[0]),
        .ch1_shift_clock_oe(sck_oe[0]), .ch1_serial_in(si[0]),
        .ch1_serial_out(so_out[0]), .ch1_serial_out_oe(so_oe[0]),
        .ch2_shift_clock_in(sck_w[1]), .ch2_shift_clock_out(sck_out[1]),
        .ch2_shift_clock_oe(sck_oe[1]), .ch2_serial_in(si[1]),
        .ch2_serial_out(so_out[1]), .ch2_serial_out_oe(so_oe[1])
    );
    dcsp_peer peer1_i (.clk_sys(clk_sys), .sck(sck_w[0]), .so(so_w[0]), .load(pload[0]),
        .tx(ptx[0]), .si(si[0]), .got(pgot[0]), .cnt(pcnt[0]));
    dcsp_peer peer2_i (.clk_sys(clk_sys), .sck(sck_w[1]), .so(so_w[1]), .load(pload[1]),
        .tx(ptx[1]), .si(si[1]), .got(pgot[1]), .cnt(pcnt[1]));

    task automatic chk(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Bus cycles; a spare edge after each keeps strobes single-driven
    task automatic wr(input logic [5:0] a, input logic [3:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [5:0] a, input logic [3:0] e);
        expq.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic idle(input logic [5:0] a, input logic [3:0] d, input int ch, input logic e);
        wr(a, d);
        repeat (2) @(posedge clk_sys);
        chk(so_out[ch] === e, "idle level");
    endtask

    // One internally clocked byte each way, or cut short after three bits
    task automatic xfer(input int ch, input bit cut);
        logic [5:0] ma;
        logic [5:0] lo;
        logic [7:0] tx;
        logic [7:0] rx;
        int n;
        ma = ch ? 6'h1B : 6'h05;
        lo = ch ? 6'h1D : 6'h06;
        tx = $urandom;
        rx = $urandom;
        ptx[ch] <= rx;
        pload[ch] <= 1'b1;
        @(posedge clk_sys);
        pload[ch] <= 1'b0;
        wr(lo, tx[3:0]);
        wr(lo + 6'h01, tx[7:4]);
        wr(ma, 4'hC);
        if (ch == 1) begin
            rd(ma, 4'h0);
        end else begin
            ch1_start_instr <= 1'b1;
            @(posedge clk_sys);
            ch1_start_instr <= 1'b0;
        end
        n = 0;
        while (pcnt[ch] != (cut ? 4'h3 : 4'h8) && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        if (cut) begin
            wr(ma, 4'hC);
            repeat (40) @(posedge clk_sys);
            chk(pcnt[ch] === 4'h3, "clock not blocked");
        end else begin
            repeat (40) @(posedge clk_sys);
            chk(pcnt[ch] === 4'h8, "pulse count");
            chk(pgot[ch] === tx, "sent byte");
            chk(sck_oe[ch] === 1'b1, "clock pin not driven");
            rd(lo, rx[3:0]);
            rd(lo + 6'h01, rx[7:4]);
            chk(so_out[ch] === (ch == 0), "idle after end");
        end
        chk(irq[ch] === 1'b1, "flag not set");
        irq_clr[ch] <= 1'b1;
        @(posedge clk_sys);
        irq_clr[ch] <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(irq[ch] === 1'b0, "flag not cleared");
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            chk(reg_rdata === expq.pop_front(), "read data");
        end
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 50000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(68275));
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        wr(6'h04, 4'hF);
        wr(6'h0C, 4'h1);
        idle(6'h28, 4'h0, 0, 1'b0);
        idle(6'h28, 4'h2, 0, 1'b1);
        idle(6'h1C, 4'h7, 1, 1'b1);
        idle(6'h1C, 4'h5, 1, 1'b0);
        foreach (wo[i]) rd(wo[i], 4'h0);
        // External clock without start must not shift
        wr(6'h05, 4'h7);
        wr(6'h06, 4'h5);
        wr(6'h07, 4'hA);
        repeat (16) begin
            ext_sck[0] <= !ext_sck[0];
            repeat (4) @(posedge clk_sys);
        end
        chk(irq === 2'b00, "flag without start");
        rd(6'h06, 4'h5);
        rd(6'h07, 4'hA);
        // Data pins as ports: generated clock runs past eight pulses, no flag
        pload[0] <= 1'b1;
        wr(6'h04, 4'hC);
        pload[0] <= 1'b0;
        wr(6'h05, 4'hC);
        ch1_start_instr <= 1'b1;
        @(posedge clk_sys);
        ch1_start_instr <= 1'b0;
        repeat (160) @(posedge clk_sys);
        chk(pcnt[0] > 4'h8 && sck_oe[0], "continuous clock");
        wr(6'h05, 4'h4);
        repeat (3) @(posedge clk_sys);
        chk(sck_oe[0] === 1'b0 && irq[0] === 1'b0, "clock pin or flag");
        wr(6'h04, 4'hF);
        for (int k = 0; k < 6; k++) xfer(k % 2, k == 2 || k == 3);
        repeat (4) @(posedge clk_sys);
        give_verdict();
    end
endmodule

bind dcsp_top dcsp_checker dcsp_checker_i (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ch1_irq_clr, .ch1_start_instr, .ch1_irq_flag, .ch2_irq_flag,
    .ch1_shift_clock_out,
    .ch2_shift_clock_out, .ch1_shift_clock_oe, .ch1_serial_out, .ch2_serial_out);
